// >>> src/gpx_pkg.sv
package gpx_pkg;
   localparam logic [3:0] ADDR_FIXED = 4'h4;
   localparam logic [2:0] REG_INPUT0 = 3'h0;
   localparam logic [2:0] REG_INPUT1 = 3'h1;
   localparam logic [2:0] REG_OUTPUT0 = 3'h2;
   localparam logic [2:0] REG_OUTPUT1 = 3'h3;
   localparam logic [2:0] REG_INVERT0 = 3'h4;
   localparam logic [2:0] REG_INVERT1 = 3'h5;
   localparam logic [2:0] REG_DIR0 = 3'h6;
   localparam logic [2:0] REG_DIR1 = 3'h7;
   localparam logic [7:0] OUTPUT_RESET = 8'hFF;
   localparam logic [7:0] INVERT_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET = 8'hFF;
   localparam logic [7:0] PTR_RESET = 8'h00;
   // SCL half period minus one, in ref_clk cycles (host divider)
   localparam logic [7:0] HALF_PERIOD = 8'h7C;
endpackage : gpx_pkg

// >>> src/gpx_bus_if.sv
interface gpx_bus_if;
   logic scl_o;
   logic scl_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic scl;
   logic sda;
   // Open-drain resolution with pull-ups
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
   modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport host (input scl, input sda, output scl_o, output scl_oe,
      output sda_host_o, output sda_host_oe);
endinterface : gpx_bus_if

// >>> src/gpx_device.sv
module gpx_device
   import gpx_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // I2C bus
   gpx_bus_if.dev bus,
   // Address straps
   input wire logic addr_strap_bit0,
   input wire logic addr_strap_bit1,
   input wire logic addr_strap_bit2,
   // Port pins
   input wire logic [7:0] port_zero_pins_i,
   input wire logic [7:0] port_one_pins_i,
   output logic [7:0] port_zero_pins_o,
   output logic [7:0] port_one_pins_o,
   output logic [7:0] port_zero_pins_oe,
   output logic [7:0] port_one_pins_oe
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
   } state_t;

   typedef struct packed {
      logic scl_q;
      logic sda_q;
      state_t st;
      logic [3:0] bitcnt;
      logic [7:0] shift;
      logic got_ptr;
      logic [2:0] ptr;
      logic [7:0] latch0;
      logic [7:0] latch1;
      logic [7:0] inv0;
      logic [7:0] inv1;
      logic [7:0] dir0;
      logic [7:0] dir1;
      logic sda_oe;
      logic sda_o;
   } dev_t;

   dev_t s_r;
   dev_t s_nxt;
   logic [15:0] pins_i;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [6:0] own_addr;
   logic [7:0] rd_byte;

   function automatic logic [2:0] pair_next(input logic [2:0] p);
      return {p[2:1], ~p[0]};
   endfunction : pair_next

   function automatic logic [7:0] read_reg(input dev_t s,
         input logic [15:0] pins, input logic [2:0] p);
      logic [7:0] v;
      v = 8'h00;
      case (p)
         REG_INPUT0: v = pins[7:0] ^ s.inv0;
         REG_INPUT1: v = pins[15:8] ^ s.inv1;
         REG_OUTPUT0: v = s.latch0;
         REG_OUTPUT1: v = s.latch1;
         REG_INVERT0: v = s.inv0;
         REG_INVERT1: v = s.inv1;
         REG_DIR0: v = s.dir0;
         default: v = s.dir1;
      endcase
      return v;
   endfunction : read_reg

   assign pins_i = {port_one_pins_i, port_zero_pins_i};
   assign own_addr = {ADDR_FIXED, addr_strap_bit2, addr_strap_bit1,
      addr_strap_bit0};
   assign rd_byte = read_reg(s_r, pins_i, s_r.ptr);
   assign scl_rise = bus.scl & ~s_r.scl_q;
   assign scl_fall = ~bus.scl & s_r.scl_q;
   assign start_c = bus.scl & s_r.scl_q & s_r.sda_q & ~bus.sda;
   assign stop_c = bus.scl & s_r.scl_q & ~s_r.sda_q & bus.sda;

   always_comb begin
      logic [7:0] sh;
      sh = {s_r.shift[6:0], bus.sda};
      s_nxt = s_r;
      s_nxt.scl_q = bus.scl;
      s_nxt.sda_q = bus.sda;
      if (start_c) begin
         // Repeated start keeps the alternated pointer
         s_nxt.st = ST_ADDR;
         s_nxt.bitcnt = 4'h0;
         s_nxt.sda_oe = 1'b0;
      end else if (stop_c) begin
         s_nxt.st = ST_IDLE;
         s_nxt.sda_oe = 1'b0;
      end else begin
         case (s_r.st)
            ST_IDLE: s_nxt.sda_oe = 1'b0;
            ST_ADDR, ST_WR: begin
               if (scl_rise) begin
                  s_nxt.shift = sh;
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
               end
               if (scl_fall && s_r.bitcnt == 4'h8) begin
                  s_nxt.bitcnt = 4'h0;
                  if (s_r.st == ST_ADDR) begin
                     if (s_r.shift[7:1] == own_addr) begin
                        s_nxt.st = ST_ADDR_ACK;
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.sda_o = 1'b0;
                     end else begin
                        s_nxt.st = ST_IDLE;
                     end
                  end else begin
                     s_nxt.st = ST_WR_ACK;
                     s_nxt.sda_oe = 1'b1;
                     s_nxt.sda_o = 1'b0;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (s_r.shift[0]) begin
                     s_nxt.st = ST_RD;
                     s_nxt.sda_oe = 1'b1;
                     s_nxt.sda_o = rd_byte[7];
                     s_nxt.shift = rd_byte;
                     s_nxt.bitcnt = 4'h1;
                  end else begin
                     s_nxt.st = ST_WR;
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.got_ptr = 1'b0;
                  end
               end
            end
            ST_WR_ACK: begin
               if (scl_rise) begin
                  if (!s_r.got_ptr) begin
                     s_nxt.ptr = s_r.shift[2:0];
                     s_nxt.got_ptr = 1'b1;
                  end else begin
                     case (s_r.ptr)
                        REG_OUTPUT0: s_nxt.latch0 = s_r.shift;
                        REG_OUTPUT1: s_nxt.latch1 = s_r.shift;
                        REG_INVERT0: s_nxt.inv0 = s_r.shift;
                        REG_INVERT1: s_nxt.inv1 = s_r.shift;
                        REG_DIR0: s_nxt.dir0 = s_r.shift;
                        REG_DIR1: s_nxt.dir1 = s_r.shift;
                        default: s_nxt.ptr = s_r.ptr;
                     endcase
                     s_nxt.ptr = pair_next(s_r.ptr);
                  end
               end
               if (scl_fall) begin
                  s_nxt.st = ST_WR;
                  s_nxt.sda_oe = 1'b0;
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  if (s_r.bitcnt == 4'h8) begin
                     s_nxt.st = ST_RD_ACK;
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.ptr = pair_next(s_r.ptr);
                  end else begin
                     s_nxt.sda_o = s_r.shift[6];
                     s_nxt.shift = {s_r.shift[6:0], 1'b0};
                     s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                  end
               end
            end
            default: begin
               // Read acknowledge: ack continues, nack ends
               if (scl_rise && bus.sda) begin
                  s_nxt.st = ST_IDLE;
               end else if (scl_fall) begin
                  s_nxt.st = ST_RD;
                  s_nxt.sda_oe = 1'b1;
                  s_nxt.sda_o = rd_byte[7];
                  s_nxt.shift = rd_byte;
                  s_nxt.bitcnt = 4'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{scl_q: 1'b1, sda_q: 1'b1, st: ST_IDLE, bitcnt: 4'h0,
            shift: 8'h00, got_ptr: 1'b0, ptr: PTR_RESET[2:0],
            latch0: OUTPUT_RESET, latch1: OUTPUT_RESET,
            inv0: INVERT_RESET, inv1: INVERT_RESET,
            dir0: DIR_RESET, dir1: DIR_RESET,
            sda_oe: 1'b0, sda_o: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.sda_dev_o = s_r.sda_o;
   assign bus.sda_dev_oe = s_r.sda_oe;
   assign port_zero_pins_o = s_r.latch0;
   assign port_one_pins_o = s_r.latch1;
   assign port_zero_pins_oe = ~s_r.dir0;
   assign port_one_pins_oe = ~s_r.dir1;
endmodule : gpx_device

// >>> src/gpx_host.sv
module gpx_host
   import gpx_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // I2C bus
   gpx_bus_if.host bus,
   // Command port
   input wire logic cmd_valid,
   input wire logic cmd_read,
   input wire logic [6:0] cmd_addr,
   input wire logic [2:0] cmd_ptr,
   input wire logic [7:0] cmd_wdata,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic rsp_ack_err,
   output logic [7:0] rsp_rdata
);
   typedef enum logic [2:0] {
      H_IDLE, H_START, H_BYTE, H_ACK, H_STOP, H_DONE
   } hstate_t;

   typedef struct packed {
      hstate_t st;
      logic [7:0] div;
      logic [1:0] ph;
      logic [3:0] bitcnt;
      logic [1:0] step;
      logic [7:0] shift;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
      logic [2:0] ptr;
      logic err;
      logic scl;
      logic sda;
      logic ready;
      logic vld;
      logic [7:0] rdata;
   } host_t;

   host_t h_r;
   host_t h_nxt;
   logic tick;
   logic [7:0] next_byte;

   // Steps: 0 addr-w, 1 pointer, 2 data, 3 addr-r then read
   always_comb begin
      next_byte = 8'h00;
      case (h_r.step)
         2'h0: next_byte = {h_r.addr, 1'b0};
         2'h1: next_byte = {5'h00, h_r.ptr};
         2'h2: next_byte = h_r.wdata;
         default: next_byte = {h_r.addr, 1'b1};
      endcase
   end

   assign tick = h_r.div == HALF_PERIOD;

   always_comb begin
      h_nxt = h_r;
      h_nxt.vld = 1'b0;
      h_nxt.div = tick ? 8'h00 : h_r.div + 8'h01;
      case (h_r.st)
         H_IDLE: begin
            h_nxt.div = 8'h00;
            h_nxt.ready = 1'b1;
            if (cmd_valid && h_r.ready) begin
               h_nxt.ready = 1'b0;
               h_nxt.rd = cmd_read;
               h_nxt.addr = cmd_addr;
               h_nxt.ptr = cmd_ptr;
               h_nxt.wdata = cmd_wdata;
               h_nxt.step = 2'h0;
               h_nxt.err = 1'b0;
               h_nxt.ph = 2'h0;
               h_nxt.st = H_START;
            end
         end
         H_START: if (tick) begin
            // Phases: sda high, scl high, sda low, scl low
            h_nxt.ph = h_r.ph + 2'h1;
            case (h_r.ph)
               2'h0: h_nxt.sda = 1'b1;
               2'h1: h_nxt.scl = 1'b1;
               2'h2: h_nxt.sda = 1'b0;
               default: begin
                  h_nxt.scl = 1'b0;
                  h_nxt.shift = next_byte;
                  h_nxt.bitcnt = 4'h0;
                  h_nxt.st = H_BYTE;
               end
            endcase
         end
         H_BYTE: if (tick) begin
            if (!h_r.scl) begin
               h_nxt.sda = h_r.rd && h_r.step == 2'h3 && h_r.ph == 2'h1 ?
                  1'b1 : h_r.shift[7];
               h_nxt.scl = 1'b1;
            end else begin
               h_nxt.scl = 1'b0;
               h_nxt.shift = {h_r.shift[6:0], bus.sda};
               h_nxt.bitcnt = h_r.bitcnt + 4'h1;
               if (h_r.bitcnt == 4'h7) h_nxt.st = H_ACK;
            end
         end
         H_ACK: if (tick) begin
            if (!h_r.scl) begin
               // Reading: single byte, so nack it
               h_nxt.sda = 1'b1;
               h_nxt.scl = 1'b1;
            end else begin
               h_nxt.scl = 1'b0;
               h_nxt.ph = 2'h0;
               if (h_r.rd && h_r.step == 2'h3 && h_r.ph == 2'h1) begin
                  h_nxt.rdata = h_r.shift;
                  h_nxt.st = H_STOP;
               end else if (bus.sda) begin
                  h_nxt.err = 1'b1;
                  h_nxt.st = H_STOP;
               end else if (h_r.step == 2'h1 && h_r.rd) begin
                  h_nxt.step = 2'h3;
                  h_nxt.st = H_START;
               end else if (h_r.step == 2'h3) begin
                  h_nxt.ph = 2'h1;
                  h_nxt.shift = 8'hFF;
                  h_nxt.bitcnt = 4'h0;
                  h_nxt.st = H_BYTE;
               end else if (h_r.step == 2'h2) begin
                  h_nxt.st = H_STOP;
               end else begin
                  h_nxt.step = h_r.step + 2'h1;
                  h_nxt.shift = h_r.step == 2'h0 ? {5'h00, h_r.ptr} :
                     h_r.wdata;
                  h_nxt.bitcnt = 4'h0;
                  h_nxt.st = H_BYTE;
               end
            end
         end
         H_STOP: if (tick) begin
            h_nxt.ph = h_r.ph + 2'h1;
            case (h_r.ph)
               2'h0: h_nxt.sda = 1'b0;
               2'h1: h_nxt.scl = 1'b1;
               default: begin
                  h_nxt.sda = 1'b1;
                  h_nxt.st = H_DONE;
               end
            endcase
         end
         default: begin
            h_nxt.vld = 1'b1;
            h_nxt.st = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         h_r <= '{st: H_IDLE, div: 8'h00, ph: 2'h0, bitcnt: 4'h0,
            step: 2'h0, shift: 8'h00, rd: 1'b0, addr: 7'h00,
            wdata: 8'h00, ptr: 3'h0, err: 1'b0, scl: 1'b1, sda: 1'b1,
            ready: 1'b0, vld: 1'b0, rdata: 8'h00};
      end else begin
         h_r <= h_nxt;
      end
   end

   assign bus.scl_o = 1'b0;
   assign bus.scl_oe = ~h_r.scl;
   assign bus.sda_host_o = 1'b0;
   assign bus.sda_host_oe = ~h_r.sda;
   assign cmd_ready = h_r.ready;
   assign rsp_valid = h_r.vld;
   assign rsp_ack_err = h_r.err;
   assign rsp_rdata = h_r.rdata;
endmodule : gpx_host

// >>> test/gpx_link_chk.sv
module gpx_link_chk
   import gpx_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Bus wires
   input wire logic sda_host_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic scl,
   input wire logic sda,
   // Address straps
   input wire logic addr_strap_bit0,
   input wire logic addr_strap_bit1,
   input wire logic addr_strap_bit2
);
   timeunit 1ns;
   timeprecision 100ps;
   logic scl_q_r, sda_q_r, first_r, rd_r, idle_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic scl_rise, start, stop, dev_low, addr_hit, ack_slot;
   assign scl_rise = scl & ~scl_q_r;
   assign start = scl & scl_q_r & sda_q_r & ~sda;
   assign stop = scl & scl_q_r & ~sda_q_r & sda;
   assign dev_low = sda_dev_oe & ~sda_dev_o;
   assign addr_hit = sh_r[7:1] ==
      {ADDR_FIXED, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
   assign ack_slot = scl_rise & (cnt_r == 4'h8);
   // Bit and byte tracking seen on the wire
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         first_r <= 1'b0;
         rd_r <= 1'b0;
         idle_r <= 1'b0;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
      end else begin
         scl_q_r <= scl;
         sda_q_r <= sda;
         if (start) begin
            cnt_r <= 4'h0;
            first_r <= 1'b1;
            rd_r <= 1'b0;
            idle_r <= 1'b0;
         end else if (stop) begin
            rd_r <= 1'b0;
         end else if (scl_rise) begin
            if (cnt_r == 4'h8) begin
               cnt_r <= 4'h0;
               first_r <= 1'b0;
               rd_r <= first_r & ~sda & sh_r[0];
               if (first_r) begin
                  idle_r <= sda;
               end
            end else begin
               cnt_r <= cnt_r + 4'h1;
               sh_r <= {sh_r[6:0], sda};
            end
         end
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   property p_dev_edge;
      $changed(dev_low) |-> !scl;
   endproperty
   a_dev_edge: assert property (p_dev_edge)
      else $error("device moved sda while scl high");
   property p_addr_ack;
      ack_slot && first_r |-> sda == !addr_hit;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("address acknowledge wrong");
   property p_wr_slot;
      scl_rise && dev_low && !rd_r |-> cnt_r == 4'h8;
   endproperty
   a_wr_slot: assert property (p_wr_slot)
      else $error("device drove sda outside ack slot");
   property p_rd_release;
      ack_slot && rd_r |-> !dev_low;
   endproperty
   a_rd_release: assert property (p_rd_release)
      else $error("device held sda in controller ack slot");
   property p_host_nack;
      ack_slot && rd_r |-> sda;
   endproperty
   a_host_nack: assert property (p_host_nack)
      else $error("last read byte acknowledged");
   property p_host_release;
      scl_rise && rd_r && cnt_r != 4'h8 |-> !sda_host_oe;
   endproperty
   a_host_release: assert property (p_host_release)
      else $error("controller drove sda during read data");
   property p_nack_idle;
      idle_r |-> !dev_low;
   endproperty
   a_nack_idle: assert property (p_nack_idle)
      else $error("device active after address mismatch");
   property p_start_bound;
      start |-> ##[1:300] !scl;
   endproperty
   a_start_bound: assert property (p_start_bound)
      else $error("no clock after start");
   c_addr_ack: cover property (ack_slot && first_r && !sda);
   c_read: cover property (ack_slot && rd_r);
   c_mismatch: cover property (idle_r);
endmodule : gpx_link_chk

// >>> test/tb_i2c_io_expander_register_port.sv
module tb_i2c_io_expander_register_port
   import gpx_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, arst_n, cmd_valid, cmd_read, cmd_ready, rsp_valid;
   logic rsp_ack_err;
   logic [2:0] strap, cmd_ptr;
   logic [6:0] cmd_addr, dev;
   logic [7:0] cmd_wdata, rsp_rdata;
   logic [15:0] ext, pins_i;
   wire [15:0] pins_o, pins_oe;
   logic [7:0] lat [2];
   logic [7:0] inv [2];
   logic [7:0] dir [2];
   logic [2:0] wr_tab [4] = '{3'h6, 3'h2, 3'h5, 3'h0};
   logic [6:0] bad_tab [3] = '{7'h01, 7'h04, 7'h40};
   int err_count, comparisons, seed;
   gpx_bus_if gpx_bus_if_i ();
   // External drive only where the pin is not an output
   assign pins_i = (pins_oe & pins_o) | (~pins_oe & ext);
   gpx_device gpx_device_i (.ref_clk(ref_clk), .arst_n(arst_n),
      .bus(gpx_bus_if_i), .addr_strap_bit0(strap[0]),
      .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
      .port_zero_pins_i(pins_i[7:0]), .port_one_pins_i(pins_i[15:8]),
      .port_zero_pins_o(pins_o[7:0]), .port_one_pins_o(pins_o[15:8]),
      .port_zero_pins_oe(pins_oe[7:0]), .port_one_pins_oe(pins_oe[15:8]));
   gpx_host gpx_host_i (.ref_clk(ref_clk), .arst_n(arst_n),
      .bus(gpx_bus_if_i), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
      .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_ack_err(rsp_ack_err), .rsp_rdata(rsp_rdata));
   gpx_link_chk gpx_link_chk_i (.ref_clk(ref_clk), .arst_n(arst_n),
      .sda_host_oe(gpx_bus_if_i.sda_host_oe),
      .sda_dev_o(gpx_bus_if_i.sda_dev_o),
      .sda_dev_oe(gpx_bus_if_i.sda_dev_oe), .scl(gpx_bus_if_i.scl),
      .sda(gpx_bus_if_i.sda), .addr_strap_bit0(strap[0]),
      .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]));
   function automatic logic [7:0] exp_reg(input logic [2:0] p);
      logic [7:0] lvl;
      lvl = (~dir[p[0]] & lat[p[0]]) | (dir[p[0]] & ext[8*p[0] +: 8]);
      case (p[2:1])
         2'h0: return lvl ^ inv[p[0]];
         2'h1: return lat[p[0]];
         2'h2: return inv[p[0]];
         default: return dir[p[0]];
      endcase
   endfunction : exp_reg
   task automatic check(input string name, input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s exp %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic xfer(input logic rd, input logic [6:0] a,
      input logic [2:0] p, input logic [7:0] d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         #1 n++;
      end
      check("cmd_ready", {7'h00, cmd_ready}, 8'h01);
      {cmd_valid, cmd_read, cmd_addr} = {1'b1, rd, a};
      {cmd_ptr, cmd_wdata} = {p, d};
      @(posedge ref_clk);
      #1 cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20000) begin
         @(posedge ref_clk);
         #1 n++;
      end
      check("rsp_valid", {7'h00, rsp_valid}, 8'h01);
   endtask : xfer
   task automatic mdl_rst();
      lat = '{OUTPUT_RESET, OUTPUT_RESET};
      inv = '{INVERT_RESET, INVERT_RESET};
      dir = '{DIR_RESET, DIR_RESET};
   endtask : mdl_rst
   task automatic pins_chk();
      for (int i = 0; i < 2; i++) begin
         check("pins_o", pins_o[8*i +: 8], lat[i]);
         check("pins_oe", pins_oe[8*i +: 8], ~dir[i]);
      end
   endtask : pins_chk
   task automatic rd_chk(input logic [2:0] p);
      xfer(1'b1, dev, p, 8'h00);
      check("rd_err", {7'h00, rsp_ack_err}, 8'h00);
      check("rdata", rsp_rdata, exp_reg(p));
   endtask : rd_chk
   task automatic summarize();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (100000) @(posedge ref_clk);
      err_count++;
      $display("MISMATCH watchdog exp done seen hang");
      summarize();
   end
   initial begin
      logic [7:0] d;
      seed = 38;
      {arst_n, cmd_valid, cmd_read, cmd_addr, cmd_ptr, cmd_wdata} = '0;
      strap = 3'($random(seed));
      ext = 16'($random(seed));
      err_count = 0;
      comparisons = 0;
      dev = {ADDR_FIXED, strap};
      mdl_rst();
      repeat (2) @(posedge ref_clk);
      #1 arst_n = 1'b1;
      pins_chk();
      rd_chk(3'h3);
      for (int i = 0; i < 3; i++) begin
         xfer(1'b0, dev ^ bad_tab[i], 3'h2, 8'h00);
         check("bad_addr", {7'h00, rsp_ack_err}, 8'h01);
      end
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         xfer(1'b0, dev, wr_tab[i], d);
         check("wr_err", {7'h00, rsp_ack_err}, 8'h00);
         case (wr_tab[i][2:1])
            2'h1: lat[wr_tab[i][0]] = d;
            2'h2: inv[wr_tab[i][0]] = d;
            2'h3: dir[wr_tab[i][0]] = d;
            default: d = 8'h00;
         endcase
      end
      pins_chk();
      ext = 16'($random(seed));
      rd_chk(3'h0);
      rd_chk(3'h1);
      rd_chk(3'h2);
      @(posedge ref_clk);
      #1 arst_n = 1'b0;
      mdl_rst();
      repeat (2) @(posedge ref_clk);
      #1 pins_chk();
      arst_n = 1'b1;
      rd_chk(3'h4);
      summarize();
   end
endmodule : tb_i2c_io_expander_register_port
